// File: flash_security_option_loader.sv
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module flash_security_option_loader (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] stored_protect_image,
    input wire logic [7:0] stored_option_image,
    input wire logic [63:0] backdoor_key_store,
    input wire logic exec_from_secure,
    input wire logic master_is_debug,
    input wire logic array_blank_verified,
    input wire logic ram_req,
    input wire logic ram_from_debug,
    input wire logic ram_from_nonsecure,
    output logic ram_grant,
    output logic ram_block,
    output logic secured,
    output logic [7:0] protect_out
);
    logic [7:0] option_q, option_d;
    logic [7:0] protect_q, protect_d;
    logic [7:0] keycfg_q, keycfg_d;
    logic [63:0] key_q, key_d;
    logic [1:0] load_cnt_q, load_cnt_d;
    fsol_pkg::fsol_state_e state_q, state_d;
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic grant_q, grant_d, block_q, block_d;
    logic key_try_q, key_try_d;
    logic key_match;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
        hit = a[15:2] == ofs[15:2];
    endfunction

    fsol_key_cmp u_cmp (
        .key_entered(key_q),
        .key_stored(backdoor_key_store),
        .key_match(key_match)
    );

    logic bus_req, wr_ok;
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    // key entry only from secure code, never from debug
    assign wr_ok = bus_req && wb_we_i && exec_from_secure && !master_is_debug;

    always_comb begin
        option_d = option_q;
        protect_d = protect_q;
        keycfg_d = keycfg_q;
        key_d = key_q;
        load_cnt_d = load_cnt_q;
        state_d = state_q;
        key_try_d = 1'b0;
        case (state_q)
            fsol_pkg::FSOL_LOAD: begin
                option_d = stored_option_image;
                protect_d = stored_protect_image;
                load_cnt_d = load_cnt_q + 2'h1;
                if (load_cnt_q == 2'(fsol_pkg::LOAD_CYCLES - 1)) begin
                    if (stored_option_image[1:0] == fsol_pkg::SEC_UNSECURED) begin
                        state_d = fsol_pkg::FSOL_OPEN;
                    end else begin
                        state_d = fsol_pkg::FSOL_SECURE;
                    end
                end
            end
            fsol_pkg::FSOL_SECURE: begin
                if (array_blank_verified) begin
                    state_d = fsol_pkg::FSOL_OPEN;
                end else if (key_try_q && option_q[fsol_pkg::KEY_EN_POS] && key_match) begin
                    state_d = fsol_pkg::FSOL_OPEN;
                end
            end
            fsol_pkg::FSOL_OPEN: state_d = fsol_pkg::FSOL_OPEN;
            default: state_d = fsol_pkg::FSOL_LOAD;
        endcase
        if (wr_ok && state_q != fsol_pkg::FSOL_LOAD) begin
            if (hit(wb_adr_i, fsol_pkg::OFS_KEY_CONFIG) && wb_sel_i[0]) begin
                keycfg_d = wb_dat_i[7:0] & fsol_pkg::KEY_CONFIG_MASK;
            end
            if (hit(wb_adr_i, fsol_pkg::OFS_PROTECT_WORK) && wb_sel_i[0]) begin
                protect_d = wb_dat_i[7:0] & fsol_pkg::PROTECT_WR_MASK;
            end
            // key words accepted only with key access on and key enabled
            if (keycfg_q[fsol_pkg::KEY_ACC_POS] && option_q[fsol_pkg::KEY_EN_POS]) begin
                if (hit(wb_adr_i, fsol_pkg::OFS_KEY_LO)) begin
                    for (int b = 0; b < 4; b++) begin
                        if (wb_sel_i[b]) begin
                            key_d[8*b +: 8] = wb_dat_i[8*b +: 8];
                        end
                    end
                end
                if (hit(wb_adr_i, fsol_pkg::OFS_KEY_HI)) begin
                    for (int b = 0; b < 4; b++) begin
                        if (wb_sel_i[b]) begin
                            key_d[32 + 8*b +: 8] = wb_dat_i[8*b +: 8];
                        end
                    end
                    key_try_d = 1'b1;
                end
            end
        end
    end

    always_comb begin
        ack_d = bus_req;
        rdat_d = 32'h0000_0000;
        if (bus_req && !wb_we_i) begin
            if (hit(wb_adr_i, fsol_pkg::OFS_OPTION_WORK)) begin
                rdat_d[15:8] = option_q;
            end else if (hit(wb_adr_i, fsol_pkg::OFS_PROTECT_WORK)) begin
                rdat_d[7:0] = protect_q;
                rdat_d[31:24] = keycfg_q;
            end else if (hit(wb_adr_i, fsol_pkg::OFS_SEC_STATUS)) begin
                rdat_d[3:0] = state_q;
                rdat_d[4] = state_q != fsol_pkg::FSOL_OPEN;
            end
        end
        // gate only; RAM array untouched by reset or low power
        grant_d = 1'b0;
        block_d = 1'b0;
        if (ram_req) begin
            if (state_q != fsol_pkg::FSOL_OPEN && (ram_from_debug || ram_from_nonsecure)) begin
                block_d = 1'b1;
            end else if (state_q != fsol_pkg::FSOL_LOAD) begin
                grant_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            option_q <= fsol_pkg::OPTION_RESET;
            protect_q <= fsol_pkg::PROTECT_RESET;
            keycfg_q <= fsol_pkg::KEY_CONFIG_RESET;
            key_q <= 64'h0000_0000_0000_0000;
            load_cnt_q <= 2'h0;
            state_q <= fsol_pkg::FSOL_LOAD;
            key_try_q <= 1'b0;
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
            grant_q <= 1'b0;
            block_q <= 1'b0;
        end else begin
            option_q <= option_d;
            protect_q <= protect_d;
            keycfg_q <= keycfg_d;
            key_q <= key_d;
            load_cnt_q <= load_cnt_d;
            state_q <= state_d;
            key_try_q <= key_try_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
            grant_q <= grant_d;
            block_q <= block_d;
        end
    end

    logic sec_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sec_q <= 1'b1;
        end else begin
            sec_q <= state_d != fsol_pkg::FSOL_OPEN;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign ram_grant = grant_q;
    assign ram_block = block_q;
    assign secured = sec_q;
    assign protect_out = protect_q;

    sequence s_key_try;
        key_try_q && option_q[fsol_pkg::KEY_EN_POS] && key_match;
    endsequence
    property p_key_unlock;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_q == fsol_pkg::FSOL_SECURE) and s_key_try |=> state_q == fsol_pkg::FSOL_OPEN;
    endproperty
    a_key_unlock: assert property (p_key_unlock) else $error("key did not unlock");
    property p_key_disabled;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_q == fsol_pkg::FSOL_SECURE && !option_q[fsol_pkg::KEY_EN_POS]
         && !array_blank_verified) |=> state_q != fsol_pkg::FSOL_OPEN;
    endproperty
    a_key_disabled: assert property (p_key_disabled) else $error("disabled key unlocked");
    property p_load_copy;
        @(posedge clk_sys) disable iff (!rst_n)
        state_q == fsol_pkg::FSOL_LOAD |=> option_q == $past(stored_option_image);
    endproperty
    a_load_copy: assert property (p_load_copy) else $error("option image not copied");
    property p_debug_no_key;
        @(posedge clk_sys) disable iff (!rst_n)
        (bus_req && master_is_debug) |=> !key_try_q;
    endproperty
    a_debug_no_key: assert property (p_debug_no_key) else $error("debug key entry taken");
    property p_nonsecure_no_key;
        @(posedge clk_sys) disable iff (!rst_n)
        (bus_req && !exec_from_secure) |=> $stable(key_q);
    endproperty
    a_nonsecure_no_key: assert property (p_nonsecure_no_key) else $error("key changed");
    property p_ram_block;
        @(posedge clk_sys) disable iff (!rst_n)
        (ram_req && ram_from_debug && state_q == fsol_pkg::FSOL_SECURE)
        |=> ram_block && !ram_grant;
    endproperty
    a_ram_block: assert property (p_ram_block) else $error("secure RAM not blocked");
    property p_unsecured_code;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_q == fsol_pkg::FSOL_LOAD && load_cnt_q == 2'h1
         && stored_option_image[1:0] == fsol_pkg::SEC_UNSECURED) |=> !secured;
    endproperty
    a_unsecured_code: assert property (p_unsecured_code) else $error("1:0 not unsecured");
    property p_other_secured;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_q == fsol_pkg::FSOL_LOAD && load_cnt_q == 2'h1
         && stored_option_image[1:0] != fsol_pkg::SEC_UNSECURED) |=> secured;
    endproperty
    a_other_secured: assert property (p_other_secured) else $error("not secured");
    property p_blank_open;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_q == fsol_pkg::FSOL_SECURE && array_blank_verified) |=> ##[0:1] !secured;
    endproperty
    a_blank_open: assert property (p_blank_open) else $error("blank did not unlock");

    // load phase lasts exactly the configured number of cycles
    sequence s_load_end;
        state_q == fsol_pkg::FSOL_LOAD ##1 state_q != fsol_pkg::FSOL_LOAD;
    endsequence
    property p_load_len;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_q == fsol_pkg::FSOL_LOAD && load_cnt_q == 2'h0)
        |=> s_load_end;
    endproperty
    a_load_len: assert property (p_load_len) else $error("load length wrong");
    property p_protect_copy;
        @(posedge clk_sys) disable iff (!rst_n)
        state_q == fsol_pkg::FSOL_LOAD
        |=> protect_q == $past(stored_protect_image);
    endproperty
    a_protect_copy: assert property (p_protect_copy) else $error("protect not copied");
    property p_load_keeps_cfg;
        @(posedge clk_sys) disable iff (!rst_n)
        state_q == fsol_pkg::FSOL_LOAD
        |=> keycfg_q == fsol_pkg::KEY_CONFIG_RESET;
    endproperty
    a_load_keeps_cfg: assert property (p_load_keeps_cfg) else $error("config written in load");
    property p_ack_one;
        @(posedge clk_sys) disable iff (!rst_n)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
    property p_ack_follows;
        @(posedge clk_sys) disable iff (!rst_n)
        bus_req |=> wb_ack_o;
    endproperty
    a_ack_follows: assert property (p_ack_follows) else $error("request not acknowledged");
    property p_open_stays;
        @(posedge clk_sys) disable iff (!rst_n)
        state_q == fsol_pkg::FSOL_OPEN
        |=> state_q == fsol_pkg::FSOL_OPEN;
    endproperty
    a_open_stays: assert property (p_open_stays) else $error("unsecured state left");
    property p_secured_level;
        @(posedge clk_sys) disable iff (!rst_n)
        secured == (state_q != fsol_pkg::FSOL_OPEN);
    endproperty
    a_secured_level: assert property (p_secured_level) else $error("secured out of step");
    property p_nonsec_block;
        @(posedge clk_sys) disable iff (!rst_n)
        (ram_req && ram_from_nonsecure && state_q == fsol_pkg::FSOL_SECURE)
        |=> ram_block && !ram_grant;
    endproperty
    a_nonsec_block: assert property (p_nonsec_block) else $error("non-secure RAM access passed");
    property p_open_grant;
        @(posedge clk_sys) disable iff (!rst_n)
        (ram_req && state_q == fsol_pkg::FSOL_OPEN)
        |=> ram_grant && !ram_block;
    endproperty
    a_open_grant: assert property (p_open_grant) else $error("open RAM access refused");
    property p_ram_idle;
        @(posedge clk_sys) disable iff (!rst_n)
        !ram_req |=> !ram_grant && !ram_block;
    endproperty
    a_ram_idle: assert property (p_ram_idle) else $error("RAM gate active while idle");
    property p_load_no_grant;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_q == fsol_pkg::FSOL_LOAD && ram_req)
        |=> !ram_grant;
    endproperty
    a_load_no_grant: assert property (p_load_no_grant) else $error("RAM granted during load");
    property p_no_key_when_off;
        @(posedge clk_sys) disable iff (!rst_n)
        !option_q[fsol_pkg::KEY_EN_POS] |=> !key_try_q;
    endproperty
    a_no_key_when_off: assert property (p_no_key_when_off) else $error("compare while disabled");
    property p_key_cmp_erased;
        @(posedge clk_sys) disable iff (!rst_n)
        key_match |-> backdoor_key_store != 64'hFFFF_FFFF_FFFF_FFFF;
    endproperty
    a_key_cmp_erased: assert property (p_key_cmp_erased) else $error("erased key matched");
    property p_key_try_secure;
        @(posedge clk_sys) disable iff (!rst_n)
        key_try_q |-> $past(exec_from_secure) && !$past(master_is_debug);
    endproperty
    a_key_try_secure: assert property (p_key_try_secure) else $error("key tried off secure");
    property p_cfg_no_debug;
        @(posedge clk_sys) disable iff (!rst_n)
        (bus_req && master_is_debug) |=> $stable(keycfg_q);
    endproperty
    a_cfg_no_debug: assert property (p_cfg_no_debug) else $error("debug changed key config");
    property p_prot_no_nonsec;
        @(posedge clk_sys) disable iff (!rst_n)
        (bus_req && !exec_from_secure && state_q != fsol_pkg::FSOL_LOAD)
        |=> $stable(protect_q);
    endproperty
    a_prot_no_nonsec: assert property (p_prot_no_nonsec) else $error("protect changed");
    property p_keycfg_mask;
        @(posedge clk_sys) disable iff (!rst_n)
        (keycfg_q & ~fsol_pkg::KEY_CONFIG_MASK) == 8'h00;
    endproperty
    a_keycfg_mask: assert property (p_keycfg_mask) else $error("reserved config bits set");
endmodule

// File: fsol_pkg.sv
package fsol_pkg;
    localparam logic [15:0] HIGH_PAGE_BASE = 16'h1800;
    localparam logic [15:0] OFS_OPTION_WORK = 16'h1821;
    localparam logic [15:0] OFS_KEY_CONFIG = 16'h1823;
    localparam logic [15:0] OFS_PROTECT_WORK = 16'h1824;
    localparam logic [15:0] OFS_KEY_STORE = 16'hFFB0;
    localparam logic [15:0] OFS_PROTECT_IMAGE = 16'hFFBD;
    localparam logic [15:0] OFS_OPTION_IMAGE = 16'hFFBF;
    // own registers: key entry words, security status
    localparam logic [15:0] OFS_KEY_LO = 16'h1828;
    localparam logic [15:0] OFS_KEY_HI = 16'h182C;
    localparam logic [15:0] OFS_SEC_STATUS = 16'h1830;
    localparam int KEY_EN_POS = 7;
    localparam int KEY_ACC_POS = 5;
    localparam logic [1:0] SEC_UNSECURED = 2'h2;
    localparam logic [7:0] PROTECT_RESET = 8'hFF;
    localparam logic [7:0] OPTION_RESET = 8'h00;
    localparam logic [7:0] KEY_CONFIG_RESET = 8'h00;
    localparam logic [7:0] PROTECT_WR_MASK = 8'hFF;
    localparam logic [7:0] KEY_CONFIG_MASK = 8'h20;
    localparam int LOAD_CYCLES = 2;
    typedef enum logic [3:0] {
        FSOL_LOAD = 4'h1,
        FSOL_SECURE = 4'h2,
        FSOL_OPEN = 4'h4,
        FSOL_IDLE = 4'h8
    } fsol_state_e;
endpackage

// File: fsol_key_cmp.sv
`timescale 1ns/1ps
module fsol_key_cmp (
    input wire logic [63:0] key_entered,
    input wire logic [63:0] key_stored,
    output logic key_match
);
    logic [7:0] byte_eq;
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_byte
            assign byte_eq[i] = key_entered[8*i +: 8] == key_stored[8*i +: 8];
        end
    endgenerate
    // an erased all-ones key never matches
    assign key_match = (&byte_eq) && (key_stored != 64'hFFFF_FFFF_FFFF_FFFF);
endmodule

// File: fsol_nv_model.sv
`timescale 1ns/1ps
module fsol_nv_model #(
    parameter logic [63:0] KEY = 64'h0123_4567_89AB_CDEF,
    parameter int ERASE_CYCLES = 40
) (
    input wire logic clk_sys,
    input wire logic [7:0] prot_in,
    input wire logic [7:0] opt_in,
    input wire logic erase,
    output logic [7:0] stored_protect_image,
    output logic [7:0] stored_option_image,
    output logic [63:0] backdoor_key_store,
    output logic array_blank_verified
);
    logic erased_q = 1'h0;
    int cnt_q = 0;
    // mass erase then blank check; erased cells read all ones
    always @(posedge clk_sys) begin
        if (erase) begin
            cnt_q <= ERASE_CYCLES;
            erased_q <= 1'h0;
        end else if (cnt_q == 1) begin
            cnt_q <= 0;
            erased_q <= 1'h1;
        end else if (cnt_q > 1) begin
            cnt_q <= cnt_q - 1;
        end
    end
    assign stored_protect_image = erased_q ? 8'hFF : prot_in;
    assign stored_option_image = erased_q ? 8'hFF : opt_in;
    assign backdoor_key_store = erased_q ? {64{1'h1}} : KEY;
    assign array_blank_verified = erased_q;
endmodule

// File: flash_security_option_loader_test.sv
`timescale 1ns/1ps
module flash_security_option_loader_test;
    localparam logic [63:0] KEY = 64'h0123_4567_89AB_CDEF;
    logic clk_sys, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, secured, blank, erase;
    logic exec_from_secure, master_is_debug, ram_req, ram_from_debug, ram_from_nonsecure;
    logic ram_grant, ram_block;
    logic [15:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [7:0] prot_img, opt_img, prot_in, opt_in, protect_out;
    logic [63:0] key_store;
    int fail_count, num_checks, n;
    flash_security_option_loader i_flash_security_option_loader (.clk_sys(clk_sys),
        .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .stored_protect_image(prot_img), .stored_option_image(opt_img),
        .backdoor_key_store(key_store), .exec_from_secure(exec_from_secure),
        .master_is_debug(master_is_debug), .array_blank_verified(blank), .ram_req(ram_req),
        .ram_from_debug(ram_from_debug), .ram_from_nonsecure(ram_from_nonsecure),
        .ram_grant(ram_grant), .ram_block(ram_block), .secured(secured),
        .protect_out(protect_out));
    fsol_nv_model #(.KEY(KEY)) i_fsol_nv_model (.clk_sys(clk_sys), .prot_in(prot_in),
        .opt_in(opt_in), .erase(erase), .stored_protect_image(prot_img),
        .stored_option_image(opt_img), .backdoor_key_store(key_store),
        .array_blank_verified(blank));
    initial begin
        clk_sys = 1'h0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task end_of_test;
        $display("checks=%0d errors=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wb(input logic we, input logic [15:0] adr, input logic [3:0] sel,
            input logic [31:0] dat);
        int k;
        @(posedge clk_sys);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (wb_ack_o !== 1'h1 && k < 50);
        chk({31'h0, wb_ack_o}, 32'h1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
    endtask
    task boot(input logic [7:0] p, input logic [7:0] o);
        @(posedge clk_sys);
        rst_n <= 1'h0;
        prot_in <= p;
        opt_in <= o;
        repeat (16) @(posedge clk_sys);
        chk({secured, protect_out}, 9'h1FF);
        rst_n <= 1'h1;
        repeat (3) @(posedge clk_sys);
    endtask
    task origin(input logic s, input logic d);
        @(posedge clk_sys);
        exec_from_secure <= s;
        master_is_debug <= d;
    endtask
    task key_entry(input logic [63:0] k);
        wb(1'h1, 16'h1820, 4'hF, 32'h2000_0020);
        wb(1'h1, 16'h1828, 4'hF, k[31:0]);
        wb(1'h1, 16'h182C, 4'hF, k[63:32]);
        repeat (4) @(posedge clk_sys);
    endtask
    task ram(input logic d, input logic ns, input logic g, input logic b);
        @(posedge clk_sys);
        ram_req <= 1'h1;
        ram_from_debug <= d;
        ram_from_nonsecure <= ns;
        repeat (2) @(posedge clk_sys);
        chk({30'h0, ram_grant, ram_block}, {30'h0, g, b});
        ram_req <= 1'h0;
    endtask
    initial begin
        {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, erase, ram_req} = 6'h0;
        {exec_from_secure, master_is_debug, ram_from_debug, ram_from_nonsecure} = 4'h0;
        {wb_adr_i, wb_sel_i, wb_dat_i, prot_in, opt_in} = 68'h0;
        fail_count = 0;
        num_checks = 0;
        boot(8'hA5, 8'h02);
        chk(secured, 1'h0);
        chk(protect_out, 8'hA5);
        wb(1'h0, 16'h1820, 4'hF, 32'h0);
        chk(rd[15:8], 8'h02);
        wb(1'h0, 16'h1824, 4'hF, 32'h0);
        chk(rd[7:0], 8'hA5);
        wb(1'h0, 16'h1830, 4'hF, 32'h0);
        chk(rd[4:0], 5'h04);
        wb(1'h0, 16'h1840, 4'hF, 32'h0);
        chk(rd, 32'h0);
        ram(1'h1, 1'h0, 1'h1, 1'h0);
        ram(1'h0, 1'h1, 1'h1, 1'h0);
        origin(1'h1, 1'h0);
        wb(1'h1, 16'h1824, 4'h1, 32'h5A);
        wb(1'h1, 16'h1820, 4'h2, 32'hFF00);
        wb(1'h0, 16'h1824, 4'hF, 32'h0);
        chk(rd[7:0], 8'h5A);
        chk(protect_out, 8'h5A);
        wb(1'h0, 16'h1820, 4'hF, 32'h0);
        chk(rd[15:8], 8'h02);
        boot(8'hFF, 8'h83);
        chk(secured, 1'h1);
        wb(1'h0, 16'h1830, 4'hF, 32'h0);
        chk(rd[4:0], 5'h12);
        ram(1'h1, 1'h0, 1'h0, 1'h1);
        ram(1'h0, 1'h1, 1'h0, 1'h1);
        ram(1'h0, 1'h0, 1'h1, 1'h0);
        origin(1'h1, 1'h1);
        key_entry(KEY);
        chk(secured, 1'h1);
        origin(1'h0, 1'h0);
        key_entry(KEY);
        chk(secured, 1'h1);
        origin(1'h1, 1'h0);
        key_entry(~KEY);
        chk(secured, 1'h1);
        key_entry(KEY);
        chk(secured, 1'h0);
        ram(1'h1, 1'h0, 1'h1, 1'h0);
        for (int c = 0; c < 4; c++) begin
            if (c != 2) begin
                boot(8'hFF, {6'h00, c[1:0]});
                chk(secured, 1'h1);
                key_entry(KEY);
                chk(secured, 1'h1);
            end
        end
        @(posedge clk_sys);
        erase <= 1'h1;
        @(posedge clk_sys);
        erase <= 1'h0;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (secured !== 1'h0 && n < 200);
        chk(secured, 1'h0);
        end_of_test;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        end_of_test;
    end
endmodule
